/* cpt_pkg.sv */
/*
  constants of the cascaded pacer timer: port offsets, control byte
  fields, access and mode codes, reset values.
  assumes a byte-wide host i/o port decoded on the low four address bits.
*/
// Summary of operation
// - square wave, even count: subtract two per edge
// - square wave terminal count toggles output, reloads
// - odd count, output high: first step one
// - odd count, output low: first step three
// - software strobe: high, counts, one-period low pulse
// - software strobe: new count loads next clock
// - software strobe: gate low holds the count
// - hardware strobe: gate rise starts or restarts count
// - control byte routed by its counter select
// - low, high, or low-then-high byte access
// - read-back latches counts of selected counters
// - read-back latches status, next read returns it
// - latch command holds count, counting continues
// - status shows output, pending load, access, mode
// - trigger rate is source over divisor product
// - stage one output clocks stage two
// - disable bit high stops pacer triggers
// - control byte field layout
// - status byte field layout
package cpt_pkg;
  // port offsets
  localparam logic [3:0] OFS_STAGE0 = 4'hc; // reserved counter, reads zero
  localparam logic [3:0] OFS_STAGE1 = 4'hd;
  localparam logic [3:0] OFS_STAGE2 = 4'he;
  localparam logic [3:0] OFS_CTRL = 4'hf;
  // control byte field positions
  localparam int CW_SEL_LO = 6;
  localparam int CW_ACC_LO = 4;
  localparam int CW_MODE_LO = 1;
  localparam int CW_FMT = 0;
  localparam int RB_CNT = 5; // count_latch_n
  localparam int RB_STA = 4; // status_latch_n
  localparam int RB_SEL_LO = 1;
  // codes
  localparam logic [1:0] SEL_READBACK = 2'h3;
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LO = 2'h1;
  localparam logic [1:0] ACC_HI = 2'h2;
  localparam logic [1:0] ACC_PAIR = 2'h3;
  localparam logic [1:0] MODE_SQUARE_LO = 2'h3; // mode x11
  localparam logic [2:0] MODE_HW = 3'h5;
  // reset values
  localparam logic [2:0] RST_MODE = 3'h4;
  localparam logic [1:0] RST_ACC = 2'h3;
  localparam logic [15:0] RST_COUNT = 16'h0000;
endpackage : cpt_pkg

/* cpt_pacer_timer.sv */
/*
  two cascaded 16-bit down counters pacing a/d triggers, with the
  control byte, byte-wise loading, count latch and status read-back.
  assumes source clock levels, gates and host strobes all synchronous
  to i_clk; source clocks well below half the i_clk rate.
*/
`timescale 1ns/10ps
`default_nettype none
module cpt_pacer_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr, // host port offset
  input wire logic i_wr, // one-cycle write strobe
  input wire logic i_rd, // one-cycle read strobe
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata, // read byte, one cycle after i_rd
  input wire logic i_src_1mhz, // source clock level, slow
  input wire logic i_src_10mhz, // source clock level, fast
  input wire logic i_clock_select_jumper, // 1 selects fast source
  input wire logic i_gate_stage1,
  input wire logic i_gate_stage2,
  input wire logic i_pacer_disable,
  output logic o_stage1_out,
  output logic o_stage2_out,
  output logic o_pacer_trigger
);
  logic [2:1] out_w; // counter output levels
  logic [2:1] src_w; // counter clock levels
  logic [2:1] gate_w;
  logic [7:0] rbyte_w [1:2]; // byte each counter would return
  logic [7:0] rdata_r;
  logic trig_out_r;

  // stage one runs from the jumper-picked source, stage two from stage one
  assign src_w[1] = i_clock_select_jumper ? i_src_10mhz : i_src_1mhz;
  assign src_w[2] = out_w[1];
  assign gate_w = {i_gate_stage2, i_gate_stage1};

  genvar g;
  generate
    for (g = 1; g <= 2; g++) begin : gen_cnt
      localparam logic [3:0] PORT = (g == 1) ? cpt_pkg::OFS_STAGE1 : cpt_pkg::OFS_STAGE2;
      logic [2:0] mode_r; // programmed mode
      logic [1:0] acc_r; // programmed access kind
      logic fmt_r; // decimal counting flag, stored and reported
      logic [15:0] cr_r; // count register from host
      logic [15:0] ce_r; // counting element
      logic [15:0] ol_r; // hold register
      logic [7:0] st_r; // latched status
      logic ol_v_r; // hold register valid
      logic st_v_r; // status latched
      logic wr_hi_r; // next paired write is the high byte
      logic rd_hi_r; // next paired read is the high byte
      logic null_r; // count written but not yet loaded
      logic pend_r; // count waiting for the counting element
      logic has_r; // a count exists since programming
      logic run_r; // counting element active
      logic out_r;
      logic trig_r; // gate rise seen, waiting for a clock edge
      logic gate_q_r;
      logic src_q_r;
      logic tick;
      logic square;
      logic hwm;
      logic wsel;
      logic rsel;
      logic cw;
      logic cw_mine;
      logic rb_mine;
      logic [15:0] step;
      logic [15:0] rv;

      // falling edge of the counter clock is the counting event
      assign tick = src_q_r & ~src_w[g];
      assign square = (mode_r[1:0] == cpt_pkg::MODE_SQUARE_LO);
      assign hwm = (mode_r == cpt_pkg::MODE_HW);
      assign wsel = i_wr && (i_addr == PORT);
      assign rsel = i_rd && (i_addr == PORT);
      assign cw = i_wr && (i_addr == cpt_pkg::OFS_CTRL);
      // control byte goes only to the counter it names
      assign cw_mine = cw && (i_wdata[7:cpt_pkg::CW_SEL_LO] == 2'(g));
      assign rb_mine = cw && (i_wdata[7:cpt_pkg::CW_SEL_LO] == cpt_pkg::SEL_READBACK)
                       && i_wdata[cpt_pkg::RB_SEL_LO + g];
      assign out_w[g] = out_r;

      // amount taken off per counting event
      always_comb begin
        if (!square) begin
          step = 16'h0001;
        end else if (ce_r[0]) begin
          step = out_r ? 16'h0001 : 16'h0003;
        end else begin
          step = 16'h0002;
        end
      end

      // clock level history for edge detection
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          src_q_r <= 1'b0;
        end else begin
          src_q_r <= src_w[g];
        end
      end

      // counter state: counting, programming, loading, latching
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          mode_r <= cpt_pkg::RST_MODE;
          acc_r <= cpt_pkg::RST_ACC;
          fmt_r <= 1'b0;
          cr_r <= cpt_pkg::RST_COUNT;
          ce_r <= cpt_pkg::RST_COUNT;
          ol_r <= cpt_pkg::RST_COUNT;
          st_r <= 8'h00;
          ol_v_r <= 1'b0;
          st_v_r <= 1'b0;
          wr_hi_r <= 1'b0;
          rd_hi_r <= 1'b0;
          null_r <= 1'b0;
          pend_r <= 1'b0;
          has_r <= 1'b0;
          run_r <= 1'b0;
          out_r <= 1'b1;
          trig_r <= 1'b0;
          gate_q_r <= 1'b0;
        end else begin
          gate_q_r <= gate_w[g];
          // counting event
          if (tick) begin
            // strobe low lasts exactly one counter clock
            if (!out_r && !square) begin
              out_r <= 1'b1;
            end
            if (hwm ? (trig_r && has_r) : (pend_r && (!run_r || !square))) begin
              // load: hardware strobe on trigger, others on next edge unless a square wave is running
              ce_r <= cr_r;
              run_r <= 1'b1;
              pend_r <= 1'b0;
              null_r <= 1'b0;
              trig_r <= 1'b0;
            end else if (run_r && (gate_w[g] || hwm)) begin
              if (ce_r <= step) begin
                if (square) begin
                  // toggle and reload, picking up any new count
                  out_r <= ~out_r;
                  ce_r <= cr_r;
                  pend_r <= 1'b0;
                  null_r <= 1'b0;
                end else begin
                  // terminal count: one low pulse, then stop
                  ce_r <= ce_r - step;
                  out_r <= 1'b0;
                  run_r <= 1'b0;
                end
              end else begin
                ce_r <= ce_r - step;
              end
            end
          end
          // gate rise arms a hardware strobe, also while counting;
          // placed after the load so that a rise landing on the load edge
          // re-arms the strobe instead of being swallowed by the load clear
          if (gate_w[g] && !gate_q_r) begin
            trig_r <= 1'b1;
          end
          // mode programming, a write here beats a same-cycle load
          if (cw_mine && (i_wdata[5:cpt_pkg::CW_ACC_LO] != cpt_pkg::ACC_LATCH)) begin
            acc_r <= i_wdata[5:cpt_pkg::CW_ACC_LO];
            mode_r <= i_wdata[3:cpt_pkg::CW_MODE_LO];
            fmt_r <= i_wdata[cpt_pkg::CW_FMT];
            out_r <= 1'b1;
            run_r <= 1'b0;
            pend_r <= 1'b0;
            has_r <= 1'b0;
            trig_r <= 1'b0;
            wr_hi_r <= 1'b0;
            rd_hi_r <= 1'b0;
            ol_v_r <= 1'b0;
            null_r <= 1'b1;
          end
          // count write by access kind
          if (wsel) begin
            if (acc_r == cpt_pkg::ACC_LO) begin
              cr_r <= {8'h00, i_wdata};
              pend_r <= 1'b1;
              null_r <= 1'b1;
              has_r <= 1'b1;
            end else if (acc_r == cpt_pkg::ACC_HI) begin
              cr_r <= {i_wdata, 8'h00};
              pend_r <= 1'b1;
              null_r <= 1'b1;
              has_r <= 1'b1;
            end else if (!wr_hi_r) begin
              // low byte first, nothing committed yet
              cr_r[7:0] <= i_wdata;
              wr_hi_r <= 1'b1;
            end else begin
              cr_r[15:8] <= i_wdata;
              wr_hi_r <= 1'b0;
              pend_r <= 1'b1;
              null_r <= 1'b1;
              has_r <= 1'b1;
            end
          end
          // count latch by command or read-back, first latch holds
          if (((cw_mine && (i_wdata[5:cpt_pkg::CW_ACC_LO] == cpt_pkg::ACC_LATCH))
               || (rb_mine && !i_wdata[cpt_pkg::RB_CNT])) && !ol_v_r) begin
            ol_r <= ce_r;
            ol_v_r <= 1'b1;
          end
          // status latch from read-back
          if (rb_mine && !i_wdata[cpt_pkg::RB_STA] && !st_v_r) begin
            st_r <= {out_r, null_r, acc_r, mode_r, fmt_r};
            st_v_r <= 1'b1;
          end
          // read side effects: status first, then count bytes
          if (rsel) begin
            if (st_v_r) begin
              st_v_r <= 1'b0;
            end else if (acc_r == cpt_pkg::ACC_PAIR) begin
              rd_hi_r <= ~rd_hi_r;
              if (rd_hi_r) begin
                ol_v_r <= 1'b0;
              end
            end else begin
              ol_v_r <= 1'b0;
            end
          end
        end
      end

      // byte this counter returns: status, held or live count
      always_comb begin
        rv = ol_v_r ? ol_r : ce_r;
        if (st_v_r) begin
          rbyte_w[g] = st_r;
        end else if (acc_r == cpt_pkg::ACC_HI) begin
          rbyte_w[g] = rv[15:8];
        end else if ((acc_r == cpt_pkg::ACC_PAIR) && rd_hi_r) begin
          rbyte_w[g] = rv[15:8];
        end else begin
          rbyte_w[g] = rv[7:0];
        end
      end
    end
  endgenerate

  // read data register, control and reserved ports read zero
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == cpt_pkg::OFS_STAGE1) begin
        rdata_r <= rbyte_w[1];
      end else if (i_addr == cpt_pkg::OFS_STAGE2) begin
        rdata_r <= rbyte_w[2];
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  // trigger to the converter, gated by the disable bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      trig_out_r <= 1'b0;
    end else begin
      trig_out_r <= out_w[2] & ~i_pacer_disable;
    end
  end

  assign o_rdata = rdata_r;
  assign o_stage1_out = gen_cnt[1].out_r;
  assign o_stage2_out = gen_cnt[2].out_r;
  assign o_pacer_trigger = trig_out_r;
endmodule : cpt_pacer_timer
`default_nettype wire

/* cpt_host_model.sv */
/* host processor model: byte-wide port writes and reads on the expansion bus.
   assumes strobes sampled on the rising edge and read data one cycle after. */
`timescale 1ns/10ps
`default_nettype none
module cpt_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [3:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata
);
  // bus idle at time zero
  initial begin
    o_addr = 4'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // one byte write, held over one rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d; // released data shows no stale byte
  endtask : wr
  // one byte read, data taken one cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
endmodule : cpt_host_model
`default_nettype wire

/* cpt_pacer_timer_checker.sv */
/* port checker of the pacer timer: trigger gating, read port, output timing.
   assumes a bind to cpt_pacer_timer with matching port names. */
`timescale 1ns/10ps
`default_nettype none
module cpt_pacer_timer_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic i_src_1mhz,
  input wire logic i_src_10mhz,
  input wire logic i_clock_select_jumper,
  input wire logic i_gate_stage1,
  input wire logic i_gate_stage2,
  input wire logic i_pacer_disable,
  input wire logic o_stage1_out,
  input wire logic o_stage2_out,
  input wire logic o_pacer_trigger
);
  // source level feeding stage one
  wire logic sel_src = i_clock_select_jumper ? i_src_10mhz : i_src_1mhz;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_TRIG_OFF: assert property (i_pacer_disable |=> !o_pacer_trigger)
    else $error("trigger high while disabled");
  AST_TRIG_FOLLOW: assert property (!i_pacer_disable |=> o_pacer_trigger == $past(o_stage2_out))
    else $error("trigger does not follow stage two");
  AST_TRIG_ROSE: assert property ($rose(o_pacer_trigger) |-> $past(o_stage2_out) && !$past(i_pacer_disable))
    else $error("trigger rose without cause");
  AST_RDATA_CAUSE: assert property ($changed(o_rdata) |-> $past(i_rd))
    else $error("read data moved without a read");
  AST_RDATA_EMPTY: assert property ((i_rd && (i_addr == cpt_pkg::OFS_STAGE0 || i_addr == cpt_pkg::OFS_CTRL))
    |=> o_rdata == 8'h00)
    else $error("reserved or control port read nonzero");
  AST_S1_EDGE: assert property ($changed(o_stage1_out) && !$past(i_wr) |-> $past(sel_src, 2) && !$past(sel_src))
    else $error("stage one moved off a source fall");
  AST_S2_EDGE: assert property ($changed(o_stage2_out) && !$past(i_wr) |->
    ($past(o_stage1_out, 2) && !$past(o_stage1_out)) || ($past(o_stage1_out, 3) && !$past(o_stage1_out, 2)))
    else $error("stage two moved off a stage one fall");
  AST_WR_SILENT: assert property (i_wr && !i_rd |=> $stable(o_rdata))
    else $error("write changed read data");
  // main scenarios reached
  COV_TRIG: cover property ($rose(o_pacer_trigger));
  COV_PROG: cover property (i_wr && i_addr == cpt_pkg::OFS_CTRL && i_wdata == 8'h76);
  COV_S1_FALL: cover property ($fell(o_stage1_out));
endmodule : cpt_pacer_timer_checker
`default_nettype wire

/* test_cascaded_pacer_timer.sv */
/* self-checking bench of the cascaded pacer timer: square wave, latch,
   read-back, strobe mode. assumes the host model and checker files. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, sn) begin samples_checked++; if ((sn) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, sn); end end
module test_cascaded_pacer_timer;
  logic i_clk, i_rst, i_wr, i_rd, s10, s1, jump, gate1, gate2, dis, o_s1, o_s2, o_trig;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, b;
  int err_count, samples_checked, cyc, n, sc;
  cpt_pacer_timer i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_src_1mhz(s1), .i_src_10mhz(s10), .i_clock_select_jumper(jump),
    .i_gate_stage1(gate1), .i_gate_stage2(gate2), .i_pacer_disable(dis), .o_stage1_out(o_s1),
    .o_stage2_out(o_s2), .o_pacer_trigger(o_trig));
  cpt_host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd),
    .o_wdata(i_wdata));
  // 50 mhz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // source levels: 10 mhz is five clocks, 1 mhz fifty clocks
  always @(negedge i_clk) begin
    sc = (sc + 1) % 50;
    s10 = (sc % 5) < 3;
    s1 = sc < 25;
  end
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  // watched output by index
  function automatic logic sig(input int k);
    return (k == 0) ? o_s1 : (k == 1) ? o_s2 : o_trig;
  endfunction : sig
  // wait for a level, bounded
  task automatic wait_lvl(input int k, input logic lvl);
    int t;
    t = 0;
    while (sig(k) !== lvl && t < 400) begin
      @(negedge i_clk);
      t++;
    end
    if (t >= 400) begin
      err_count++;
      $display("Error wait expected %h seen %h", lvl, sig(k));
    end
  endtask : wait_lvl
  // clocks spent at one level after an edge into it
  task automatic meas(input int k, input logic lvl, output int m);
    wait_lvl(k, !lvl);
    wait_lvl(k, lvl);
    m = 0;
    while (sig(k) === lvl && m < 400) begin
      @(negedge i_clk);
      m++;
    end
  endtask : meas
  // counts and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    {i_rst, jump, gate1, gate2, dis, sc, s10, s1, err_count, samples_checked, cyc} = '0;
    {i_rst, jump, gate1, gate2, dis} = 5'h1f;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    `CHK("stage1 reset", 1'b1, o_s1)
    `CHK("trigger disabled", 1'b0, o_trig)
    host.rd(4'hc, b);
    `CHK("reserved port", 8'h00, b)
    host.rd(4'hf, b);
    `CHK("control port", 8'h00, b)
    $display("test reset done");
    // pacer setup, stage one five, stage two four
    host.wr(4'hf, 8'h76);
    host.wr(4'hd, 8'h05);
    host.wr(4'hd, 8'h00);
    host.wr(4'hf, 8'hb6);
    host.wr(4'he, 8'h04);
    host.wr(4'he, 8'h00);
    dis = 1'b0;
    meas(0, 1'b1, n);
    `CHK("stage1 high", 15, n)
    meas(0, 1'b0, n);
    `CHK("stage1 low", 10, n)
    meas(1, 1'b1, n);
    `CHK("stage2 high", 50, n)
    meas(2, 1'b1, n);
    `CHK("trigger high", 50, n)
    meas(2, 1'b0, n);
    `CHK("trigger low", 50, n)
    dis = 1'b1;
    repeat (120) @(negedge i_clk);
    `CHK("trigger stopped", 1'b0, o_trig)
    $display("test square done");
    // freeze stage one right after its reload
    wait_lvl(0, 1'b0);
    wait_lvl(0, 1'b1);
    gate1 = 1'b0;
    host.wr(4'hf, 8'h40);
    host.rd(4'hd, b);
    `CHK("latch low", 8'h05, b)
    host.rd(4'hd, b);
    `CHK("latch high", 8'h00, b)
    host.wr(4'hf, 8'he4);
    host.rd(4'hd, b);
    `CHK("status", 8'hb6, b)
    host.wr(4'hf, 8'hd4);
    host.rd(4'hd, b);
    `CHK("readback low", 8'h05, b)
    host.rd(4'hd, b);
    `CHK("readback high", 8'h00, b)
    $display("test latch done");
    // software strobe, count three held by gate
    host.wr(4'hf, 8'h78);
    `CHK("strobe idle", 1'b1, o_s1)
    host.wr(4'hd, 8'h03);
    host.wr(4'hd, 8'h00);
    repeat (40) @(negedge i_clk);
    `CHK("gate hold", 1'b1, o_s1)
    host.wr(4'hf, 8'h40);
    host.rd(4'hd, b);
    `CHK("held count low", 8'h03, b)
    host.rd(4'hd, b);
    `CHK("held count high", 8'h00, b)
    gate1 = 1'b1;
    meas(0, 1'b0, n);
    `CHK("strobe width", 5, n)
    $display("test strobe done");
    // hardware strobe on the slow source, low byte only access
    jump = 1'b0;
    host.wr(4'hf, 8'h5a);
    host.wr(4'hd, 8'h02);
    gate1 = 1'b0;
    n = 0;
    repeat (200) begin
      @(negedge i_clk);
      n += (o_s1 === 1'b0);
    end
    `CHK("no strobe before gate rise", 0, n)
    gate1 = 1'b1;
    meas(0, 1'b0, n);
    `CHK("hw strobe width", 50, n)
    $display("test hwstrobe done");
    test_done();
  end
endmodule : test_cascaded_pacer_timer
bind cpt_pacer_timer cpt_pacer_timer_checker i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_src_1mhz(i_src_1mhz),
  .i_src_10mhz(i_src_10mhz), .i_clock_select_jumper(i_clock_select_jumper), .i_gate_stage1(i_gate_stage1),
  .i_gate_stage2(i_gate_stage2), .i_pacer_disable(i_pacer_disable), .o_stage1_out(o_stage1_out),
  .o_stage2_out(o_stage2_out), .o_pacer_trigger(o_pacer_trigger));
`default_nettype wire
